// ==== logic/sldac_dev.sv ====
// converter end: shift register, latch, async receiver, modulator, fault
// assumes link pins arrive asynchronous to i_clk and are resynchronised
`default_nettype none
module sldac_dev
    import sldac_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    sldac_link_if.dev link,
    input wire logic i_loop_fault,
    input wire logic [1:0] i_span,
    output logic o_isrc_on,
    output logic [1:0] o_span,
    output logic [15:0] o_code,
    output logic o_async,
    output logic o_frame_err
);
    typedef enum logic [1:0] {RX_IDLE, RX_ARM, RX_FRAME} sldac_rx_t;

    logic [SY_N-1:0] sy1_q, sy2_q;
    logic sclk_prev_q, sdi_prev_q;
    logic [SY_N-1:0] pins;
    logic tick, sdi_s, async_s;

    assign pins = {i_loop_fault, link.latch_weak, link.latch,
        link.sdi, link.sclk};

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sy1_q <= '0;
            sy2_q <= '0;
            sclk_prev_q <= 1'b0;
            sdi_prev_q <= 1'b1;
        end else begin
            sy1_q <= pins;
            sy2_q <= sy1_q;
            sclk_prev_q <= sy2_q[SY_SCLK];
            sdi_prev_q <= sy2_q[SY_SDI];
        end
    end

    assign sdi_s = sy2_q[SY_SDI];
    assign async_s = sy2_q[SY_WEAK];
    assign tick = sy2_q[SY_SCLK] & ~sclk_prev_q;

    logic latch_prev_q, latch_prev_d;
    logic [15:0] sr_q, sr_d, code_q, code_d;
    logic [8:0] cnt_q, cnt_d;
    sldac_rx_t rx_q, rx_d;
    logic err_q, err_d, sdo_q, sdo_d;
    logic [8:0] cnt_n;
    logic [8:0] cnt_off;

    always_comb begin
        latch_prev_d = sy2_q[SY_LATCH];
        sr_d = sr_q;
        code_d = code_q;
        cnt_d = cnt_q;
        rx_d = rx_q;
        err_d = err_q;
        cnt_n = cnt_q + 9'h001;
        cnt_off = cnt_n - TICK_FIRST;
        if (!async_s) begin
            rx_d = RX_IDLE;
            err_d = 1'b0;
            if (tick) begin
                sr_d = {sr_q[CODE_MSB-1:0], sdi_s};
            end
            // one shared strobe loads each chained device
            if (sy2_q[SY_LATCH] && !latch_prev_q) begin
                code_d = sr_q;
            end
        end else begin
            // the error pulse lasts one link clock period
            if (tick) begin
                err_d = 1'b0;
            end
            case (rx_q)
                RX_IDLE: begin
                    // falling start edge from idle high
                    if (!sdi_s && sdi_prev_q) begin
                        rx_d = RX_ARM;
                    end
                end
                RX_ARM: begin
                    // cell starts at the next clock
                    if (tick) begin
                        rx_d = RX_FRAME;
                        cnt_d = '0;
                    end
                end
                RX_FRAME: begin
                    if (tick) begin
                        cnt_d = cnt_n;
                        // mid-cell samples at 24, 40, ...
                        if (cnt_n >= TICK_FIRST && cnt_off[3:0] == 4'h0 &&
                                cnt_n < TICK_STOP) begin
                            sr_d = {sr_q[CODE_MSB-1:0], sdi_s};
                        end
                        if (cnt_n == TICK_STOP) begin
                            rx_d = RX_IDLE;
                            if (sdi_s) begin
                                code_d = sr_q;
                            end else begin
                                err_d = 1'b1;
                            end
                        end
                    end
                end
                default: rx_d = RX_IDLE;
            endcase
        end
    end

    // chain output shows the bit leaving the register; in async mode it shows the error pulse
    always_comb begin
        if (async_s) begin
            sdo_d = err_d;
        end else begin
            sdo_d = sr_d[CODE_MSB];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            latch_prev_q <= 1'b0;
            sr_q <= CODE_RESET;
            code_q <= CODE_RESET;
            cnt_q <= '0;
            rx_q <= RX_IDLE;
            err_q <= 1'b0;
            sdo_q <= 1'b0;
        end else begin
            latch_prev_q <= latch_prev_d;
            sr_q <= sr_d;
            code_q <= code_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            err_q <= err_d;
            sdo_q <= sdo_d;
        end
    end

    // modulator: two integrators with full-scale bit feedback
    localparam logic signed [23:0] INT_MAX = 24'sh7FFFFF;
    localparam logic signed [23:0] INT_MIN = 24'sh800000;
    logic signed [23:0] int1_q, int1_d, int2_q, int2_d, fb;
    logic signed [25:0] int1_s, int2_s;
    logic bit_q, bit_d;

    // near full scale the second integrator swings far; clamp, never wrap
    function automatic logic signed [23:0] sat24(
        input logic signed [25:0] v
    );
        logic signed [23:0] r;
        r = v[23:0];
        if (v > 26'(INT_MAX)) begin
            r = INT_MAX;
        end else if (v < 26'(INT_MIN)) begin
            r = INT_MIN;
        end
        return r;
    endfunction

    always_comb begin
        fb = bit_q ? MOD_FS : '0;
        int1_s = 26'(int1_q) + 26'($signed({8'h00, code_q})) - 26'(fb);
        int1_d = sat24(int1_s);
        int2_s = 26'(int2_q) + 26'(int1_d) - 26'(fb);
        int2_d = sat24(int2_s);
        // zero counts as low so a zero code never starts with a pulse
        bit_d = ~int2_d[23] & (int2_d != '0);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            int1_q <= '0;
            int2_q <= '0;
            bit_q <= 1'b0;
        end else begin
            int1_q <= int1_d;
            int2_q <= int2_d;
            bit_q <= bit_d;
        end
    end

    // span steering; code maps linearly in the analog stage
    logic [1:0] span_q, span_d;
    logic fault_q;
    always_comb begin
        case (i_span)
            SPAN_4_20, SPAN_0_20, SPAN_0_24: span_d = i_span;
            default: span_d = SPAN_4_20;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            span_q <= SPAN_4_20;
            fault_q <= 1'b0;
        end else begin
            span_q <= span_d;
            fault_q <= sy2_q[SY_FAULT];
        end
    end

    // bit drives the current switch directly
    assign o_isrc_on = bit_q;
    // zero code gives the span bottom
    assign o_code = code_q;
    assign o_span = span_q;
    assign o_async = sy2_q[SY_WEAK];
    assign o_frame_err = err_q;
    assign link.sdo = sdo_q;
    // open drain: only ever pulls low
    assign link.fault_n_o = 1'b0;
    assign link.fault_n_oe = fault_q;
endmodule // sldac_dev
`default_nettype wire

// ==== logic/sldac_host.sv ====
// host end: sends one 16-bit word in three-wire or async framed mode
// assumes a single converter on the link; chains reuse the same timing
`default_nettype none
module sldac_host
    import sldac_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    sldac_link_if.host link,
    input wire logic i_async,
    input wire logic i_start,
    input wire logic [15:0] i_word,
    output logic o_busy,
    output logic o_fault
);
    typedef enum logic [2:0] {
        H_IDLE, H_SHIFT, H_SETTLE, H_LATCH, H_FRAME
    } sldac_hst_t;

    sldac_hst_t st_q, st_d;
    logic [3:0] div_q, div_d;
    logic [3:0] tk_q, tk_d;
    logic [4:0] bit_q, bit_d;
    logic [17:0] sh_q, sh_d;
    logic sclk_q, sclk_d, sdi_q, sdi_d, lat_q, lat_d;
    logic busy_q, busy_d;
    logic [1:0] fsy_q;
    logic fault_q;

    always_comb begin
        st_d = st_q;
        div_d = div_q;
        tk_d = tk_q;
        bit_d = bit_q;
        sh_d = sh_q;
        sclk_d = sclk_q;
        sdi_d = sdi_q;
        lat_d = lat_q;
        busy_d = busy_q;
        // async clock free-runs at 16x the bit rate
        if (i_async) begin
            lat_d = 1'b1;
            if (div_q == HALF_ASY - 4'h1) begin
                div_d = '0;
                sclk_d = ~sclk_q;
            end else begin
                div_d = div_q + 4'h1;
            end
        end
        case (st_q)
            H_IDLE: begin
                sdi_d = 1'b1;
                busy_d = 1'b0;
                if (!i_async) begin
                    sclk_d = 1'b0;
                    div_d = '0;
                end
                if (i_start) begin
                    busy_d = 1'b1;
                    bit_d = '0;
                    tk_d = '0;
                    if (i_async) begin
                        sh_d = {1'b0, i_word, 1'b1};
                        st_d = H_FRAME;
                    end else begin
                        sh_d = {i_word, 2'b00};
                        sdi_d = i_word[CODE_MSB];
                        lat_d = 1'b0;
                        div_d = '0;
                        st_d = H_SHIFT;
                    end
                end
            end
            H_SHIFT: begin
                if (div_q == HALF_TW - 4'h1) begin
                    div_d = '0;
                    sclk_d = ~sclk_q;
                    if (sclk_q) begin
                        sh_d = {sh_q[16:0], 1'b0};
                        sdi_d = sh_q[16];
                        bit_d = bit_q + 5'h01;
                        if (bit_q == 5'(WORD_BITS - 1)) begin
                            st_d = H_SETTLE;
                        end
                    end
                end else begin
                    div_d = div_q + 4'h1;
                end
            end
            H_SETTLE: begin
                // clock held low before and during latch
                if (div_q == HALF_TW - 4'h1) begin
                    div_d = '0;
                    lat_d = 1'b1;
                    st_d = H_LATCH;
                end else begin
                    div_d = div_q + 4'h1;
                end
            end
            H_LATCH: begin
                if (div_q == HALF_TW - 4'h1) begin
                    div_d = '0;
                    st_d = H_IDLE;
                end else begin
                    div_d = div_q + 4'h1;
                end
            end
            H_FRAME: begin
                // bits change on falling edges, 16 ticks apiece
                if (div_q == HALF_ASY - 4'h1 && sclk_q) begin
                    if (tk_q == 4'h0) begin
                        sdi_d = sh_q[17];
                        sh_d = {sh_q[16:0], 1'b1};
                        bit_d = bit_q + 5'h01;
                        if (bit_q == 5'(FRAME_BITS)) begin
                            sdi_d = 1'b1;
                            st_d = H_IDLE;
                        end
                    end
                    tk_d = tk_q + 4'h1;
                end
            end
            default: st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= H_IDLE;
            div_q <= '0;
            tk_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            sclk_q <= 1'b0;
            sdi_q <= 1'b1;
            lat_q <= 1'b1;
            busy_q <= 1'b0;
            fsy_q <= 2'h0;
            fault_q <= 1'b0;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            tk_q <= tk_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            sclk_q <= sclk_d;
            sdi_q <= sdi_d;
            lat_q <= lat_d;
            busy_q <= busy_d;
            fsy_q <= {fsy_q[0], ~link.fault_n};
            fault_q <= fsy_q[1];
        end
    end

    assign link.sclk = sclk_q;
    assign link.sdi = sdi_q;
    assign link.latch_o = lat_q;
    // async leaves the latch to its pull-up
    assign link.latch_oe = ~i_async;
    assign o_busy = busy_q;
    assign o_fault = fault_q;
endmodule // sldac_host
`default_nettype wire

// ==== logic/sldac_link_if.sv ====
// pin-level link between host and converter
// the latch pin has a pull-up: undriven it reads high and marks async mode
`default_nettype none
interface sldac_link_if;
    logic sclk;
    logic sdi;
    logic latch_o;
    logic latch_oe;
    logic latch;
    logic latch_weak;
    logic sdo;
    logic fault_n_o;
    logic fault_n_oe;
    logic fault_n;
    assign latch = latch_oe ? latch_o : 1'b1;
    assign latch_weak = ~latch_oe;
    assign fault_n = fault_n_oe ? fault_n_o : 1'b1;
    modport dev (
        input sclk, sdi, latch, latch_weak,
        output sdo, fault_n_o, fault_n_oe
    );
    modport host (
        output sclk, sdi, latch_o, latch_oe,
        input sdo, fault_n
    );
endinterface
`default_nettype wire

// ==== logic/sldac_pkg.sv ====
// constants shared by both ends of the serial loop converter link
// assumes one 25 MHz system clock at each end
`default_nettype none
package sldac_pkg;
    localparam int CLK_NS = 40;
    localparam int WORD_BITS = 16;
    localparam int CODE_MSB = WORD_BITS - 1;
    // three-wire shift clock: least period 300 ns
    localparam int TW_PERIOD_NS = 300;
    localparam int TW_HALF =
        (TW_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
    // async clock: 16 ticks per bit, at most 2400 kHz
    localparam int ASY_MAX_KHZ = 2400;
    localparam int ASY_HALF =
        (1000000 + ASY_MAX_KHZ * 2 * CLK_NS - 1) / (ASY_MAX_KHZ * 2 * CLK_NS);
    localparam int TICKS_PER_BIT = 16;
    localparam int FIRST_SAMPLE = 24;
    localparam int FRAME_BITS = WORD_BITS + 2;
    localparam logic [8:0] TICK_FIRST = 9'h018;
    localparam logic [8:0] TICK_STOP = 9'h118;
    localparam logic [3:0] TICK_PHASE = 4'h8;
    localparam logic [3:0] HALF_TW = 4'(TW_HALF);
    localparam logic [3:0] HALF_ASY = 4'(ASY_HALF);
    localparam logic [15:0] CODE_RESET = 16'h0000;
    // modulator feedback equals one full-scale step
    localparam logic signed [23:0] MOD_FS = 24'sh010000;
    // span selection codes
    localparam logic [1:0] SPAN_4_20 = 2'h0;
    localparam logic [1:0] SPAN_0_20 = 2'h1;
    localparam logic [1:0] SPAN_0_24 = 2'h2;
    // synchroniser lanes
    localparam int SY_SCLK = 0;
    localparam int SY_SDI = 1;
    localparam int SY_LATCH = 2;
    localparam int SY_WEAK = 3;
    localparam int SY_FAULT = 4;
    localparam int SY_N = 5;
endpackage
`default_nettype wire

// ==== verif/sldac_link_asserts.sv ====
// checker on the pins of the link between host and converter
// assumes one system clock and a synchronous active-high reset
`default_nettype none
module sldac_link_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic latch,
    input wire logic latch_oe,
    input wire logic latch_weak,
    input wire logic sdo,
    input wire logic fault_n_o,
    input wire logic fault_n_oe
);
    logic [4:0] cnt_q, cnt_d;
    logic first_q, first_d, sclk_q, latch_q;
    // shift count and first bit of the word now being loaded
    always_comb begin
        cnt_d = cnt_q;
        first_d = first_q;
        if (latch_q && !latch) begin
            cnt_d = 5'h00;
            first_d = sdi;
        end else if (sclk && !sclk_q) begin
            cnt_d = cnt_q + 5'h01;
        end
    end
    always_ff @(posedge i_clk) begin
        cnt_q <= i_rst ? 5'h00 : cnt_d;
        first_q <= first_d;
        sclk_q <= sclk;
        latch_q <= latch;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_count;
        latch_oe && $rose(latch) |-> cnt_q == 5'h10;
    endproperty
    a_count: assert property (p_count)
        else $error("latch after wrong shift count");
    property p_still;
        latch_oe && $rose(latch) |-> !sclk && !$past(sclk);
    endproperty
    a_still: assert property (p_still)
        else $error("shift clock moving at latch");
    property p_tw_high;
        latch_oe && $rose(sclk) |-> sclk [*4] ##1 !sclk;
    endproperty
    a_tw_high: assert property (p_tw_high)
        else $error("shift clock high time wrong");
    property p_asy_high;
        !latch_oe && $rose(sclk) |-> sclk [*6] ##1 !sclk;
    endproperty
    a_asy_high: assert property (p_asy_high)
        else $error("async clock high time wrong");
    property p_sdi_fall;
        latch_oe && !latch && $changed(sdi) |-> $fell(sclk) || $fell(latch);
    endproperty
    a_sdi_fall: assert property (p_sdi_fall)
        else $error("data changed away from clock fall");
    property p_latch_low;
        latch_oe && $rose(sclk) |-> !latch;
    endproperty
    a_latch_low: assert property (p_latch_low)
        else $error("shift while latch high");
    property p_chain;
        latch_oe && $rose(latch) |-> ##3 sdo == first_q;
    endproperty
    a_chain: assert property (p_chain)
        else $error("chain output not the leaving bit");
    property p_no_err;
        latch_weak && $past(latch_weak, 6) |-> !sdo;
    endproperty
    a_no_err: assert property (p_no_err)
        else $error("error pulse on a good frame");
    property p_fault_low;
        fault_n_o == 1'b0;
    endproperty
    a_fault_low: assert property (p_fault_low)
        else $error("fault pin drives high");
    c_latch: cover property (latch_oe && $rose(latch));
    c_async: cover property (latch_weak && $fell(sdi));
    c_fault: cover property (fault_n_oe);
endmodule // sldac_link_asserts
`default_nettype wire

// ==== verif/tb_serial_loop_dac_input_logic.sv ====
// bench: host and converter face each other on one link
// a second converter sits in the chain, then on a bench-driven link
`default_nettype none
module tb_serial_loop_dac_input_logic;
    import sldac_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_rst, h_async, h_start, loop_flt, chain;
    logic b_sclk, b_sdi, b_latch, b_oe, err_seen, sdo_seen;
    logic isrc, busy, h_fault, d_async, d_err, b_err;
    logic [1:0] span, d_span;
    logic [15:0] word, code, b_code, w, prev;
    int fail_count, comparisons, seed;
    sldac_link_if link ();
    sldac_link_if link_b ();
    // second converter: chained behind the first, or driven by the bench
    assign link_b.sclk = chain ? link.sclk : b_sclk;
    assign link_b.sdi = chain ? link.sdo : b_sdi;
    assign link_b.latch_o = chain ? link.latch_o : b_latch;
    assign link_b.latch_oe = chain ? link.latch_oe : b_oe;
    sldac_host sldac_host_inst (.i_clk(i_clk), .i_rst(i_rst), .link(link),
        .i_async(h_async), .i_start(h_start), .i_word(word),
        .o_busy(busy), .o_fault(h_fault));
    sldac_dev sldac_dev_inst (.i_clk(i_clk), .i_rst(i_rst), .link(link),
        .i_loop_fault(loop_flt), .i_span(span), .o_isrc_on(isrc),
        .o_span(d_span), .o_code(code), .o_async(d_async),
        .o_frame_err(d_err));
    sldac_dev sldac_dev_inst2 (.i_clk(i_clk), .i_rst(i_rst), .link(link_b),
        .i_loop_fault(1'b0), .i_span(2'h0), .o_isrc_on(), .o_span(),
        .o_code(b_code), .o_async(), .o_frame_err(b_err));
    sldac_link_asserts sldac_link_asserts_inst (.i_clk(i_clk),
        .i_rst(i_rst), .sclk(link.sclk), .sdi(link.sdi),
        .latch(link.latch), .latch_oe(link.latch_oe),
        .latch_weak(link.latch_weak), .sdo(link.sdo),
        .fault_n_o(link.fault_n_o), .fault_n_oe(link.fault_n_oe));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    function automatic logic [1:0] exp_span(input logic [1:0] s);
        return (s == 2'h3) ? SPAN_4_20 : s;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic clk1();
        @(posedge i_clk);
        #2;
        if (b_err === 1'b1) err_seen = 1'b1;
        if (link_b.sdo === 1'b1) sdo_seen = 1'b1;
    endtask
    task automatic send(input logic [15:0] v, input logic a);
        int n;
        n = 0;
        word = v;
        h_async = a;
        span = 2'($random(seed));
        repeat (6) clk1();
        h_start = 1'b1;
        clk1();
        h_start = 1'b0;
        while (busy !== 1'b0) begin
            clk1();
            n++;
            if (n > 5000) begin
                fail_count++;
                $display("CHECK FAILED %0t: host stuck busy", $time);
                summarize();
            end
        end
        repeat (6) clk1();
    endtask
    // ones density of the modulator must follow code / 65536
    task automatic density(input logic [15:0] c);
        int n, e;
        n = 0;
        e = int'(c >> 4);
        repeat (64) clk1();
        repeat (4096) begin
            clk1();
            n += (isrc === 1'b1);
        end
        check(16'(n > e + 6 || n + 6 < e), 16'h0000);
    endtask
    task automatic tick();
        b_sclk = 1'b1;
        repeat (6) clk1();
        b_sclk = 1'b0;
        repeat (6) clk1();
    endtask
    // async frame: start 0, msb first, chosen stop level, then idle high
    task automatic frame(input logic [15:0] v, input logic stop);
        logic [17:0] bits;
        bits = {1'b0, v, stop};
        for (int i = 17; i >= 0; i--) begin
            b_sdi = bits[i];
            repeat (16) tick();
        end
        b_sdi = 1'b1;
        repeat (4) tick();
    endtask
    initial begin
        seed = 32'h9a33;
        fail_count = 0;
        comparisons = 0;
        {i_rst, h_async, h_start, loop_flt, chain} = 5'h11;
        {b_sclk, b_sdi, b_latch, b_oe} = 4'h7;
        {err_seen, sdo_seen, word, span} = '0;
        repeat (8) @(posedge i_clk);
        #2;
        i_rst = 1'b0;
        clk1();
        check(code, CODE_RESET);
        check(d_span, SPAN_4_20);
        density(CODE_RESET);
        prev = CODE_RESET;
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8001 : 16'($random(seed));
            send(w, 1'b0);
            check(code, w);
            check(b_code, prev);
            check(d_span, exp_span(span));
            if (i < 2) density(w);
            prev = w;
        end
        loop_flt = 1'b1;
        repeat (10) clk1();
        check(link.fault_n, 1'b0);
        check(h_fault, 1'b1);
        loop_flt = 1'b0;
        repeat (10) clk1();
        check(link.fault_n, 1'b1);
        chain = 1'b0;
        for (int i = 0; i < 3; i++) begin
            w = (i == 0) ? 16'h7FFE : 16'($random(seed));
            send(w, 1'b1);
            check(d_async, 1'b1);
            check(code, w);
            check(d_err, 1'b0);
        end
        b_oe = 1'b0;
        repeat (8) clk1();
        err_seen = 1'b0;
        w = 16'($random(seed));
        frame(w, 1'b1);
        check(b_code, w);
        check(err_seen, 1'b0);
        err_seen = 1'b0;
        sdo_seen = 1'b0;
        frame(~w, 1'b0);
        check(err_seen, 1'b1);
        check(sdo_seen, 1'b1);
        check(b_code, w);
        summarize();
    end
endmodule // tb_serial_loop_dac_input_logic
`default_nettype wire
